//--- bench/dsc_host.sv
// host model reading results over the serial or parallel port
module dsc_host (
    output logic chip_select_n_o,
    output logic read_n_o,
    output logic serial_clk_o,
    input wire logic serial_result_out_i
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {chip_select_n_o, read_n_o, serial_clk_o} = 3'h6;
    task automatic select(input logic on);
        chip_select_n_o = !on;
        read_n_o = !on;
    endtask
    // clock stands still outside frames; phases keep edges off the system clock
    task automatic read_serial(input int nbits, output logic [31:0] w);
        w = 32'h0;
        select(1'b1);
        #64;
        for (int i = 0; i < nbits; i++) begin
            w = {w[30:0], serial_result_out_i};
            serial_clk_o = 1'b1;
            #62;
            serial_clk_o = 1'b0;
            #63;
        end
        select(1'b0);
    endtask
endmodule

//--- bench/dsc_sva.sv
// assertion checker for the dual converter conversion control
module dsc_sva #(
    parameter CONV_CYC = 4,
    parameter ACQ_CYC = 4
) (
    input wire clk_sys_i,
    input wire sys_rst_i,
    input wire power_down_i,
    input wire serial_parallel_select_i,
    input wire chip_select_n_i,
    input wire read_n_i,
    input wire busy_o,
    input wire end_of_conv_n_o,
    input wire [15:0] parallel_data_oe_o,
    input wire serial_result_out_oe_o,
    input wire incomplete_read_flag_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    logic [15:0] bcnt;
    wire rd_en = !chip_select_n_i && !read_n_i;
    always @(posedge clk_sys_i) bcnt <= (sys_rst_i || !busy_o) ? 16'h0 : bcnt + 16'h1;
    sequence s_eoc_tail; !end_of_conv_n_o ##1 end_of_conv_n_o; endsequence
    sequence s_flag_tail; incomplete_read_flag_o ##1 !incomplete_read_flag_o; endsequence
    a_busy_len: assert property ($fell(busy_o) && !$past(sys_rst_i) |-> bcnt == 2 * CONV_CYC)
        else $error("busy width wrong");
    a_eoc_pulse: assert property ($fell(end_of_conv_n_o) |=> s_eoc_tail)
        else $error("end of conversion pulse width wrong");
    a_eoc_in_conv: assert property ($fell(end_of_conv_n_o) |-> $past(busy_o))
        else $error("end of conversion outside a conversion");
    a_flag_pulse: assert property ($rose(incomplete_read_flag_o) |=> s_flag_tail)
        else $error("error flag pulse width wrong");
    a_oe_gate: assert property (|parallel_data_oe_o |-> rd_en)
        else $error("parallel bus enabled without select and read");
    a_ser_oe: assert property (serial_result_out_oe_o |-> rd_en && serial_parallel_select_i)
        else $error("serial output enabled wrongly");
    a_hi_release: assert property (serial_parallel_select_i |-> parallel_data_oe_o[15:12] == 4'h0)
        else $error("upper bits driven in serial mode");
    a_par_drive: assert property (!serial_parallel_select_i && rd_en |-> &parallel_data_oe_o)
        else $error("parallel bus not driven");
    a_reset_abort: assert property (disable iff (1'b0) sys_rst_i |=> !busy_o && end_of_conv_n_o)
        else $error("conversion survives reset");
    a_pd_block: assert property ((power_down_i && !busy_o) [*6] |=> !busy_o)
        else $error("conversion started in power down");
endmodule
bind dsc_conv_ctrl dsc_sva #(.CONV_CYC(CONV_CYC), .ACQ_CYC(ACQ_CYC)) dsc_sva_i (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .power_down_i(power_down_i),
    .serial_parallel_select_i(serial_parallel_select_i), .chip_select_n_i(chip_select_n_i),
    .read_n_i(read_n_i), .busy_o(busy_o), .end_of_conv_n_o(end_of_conv_n_o),
    .parallel_data_oe_o(parallel_data_oe_o), .serial_result_out_oe_o(serial_result_out_oe_o),
    .incomplete_read_flag_o(incomplete_read_flag_o));

//--- bench/testbench.sv
// self-checking bench for the dual converter conversion control
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0, sys_rst = 1'b1, cnv_n = 1'b1, pd = 1'b0, imp = 1'b0;
    logic ser = 1'b0, ext = 1'b1, ord = 1'b0;
    wire busy, eoc_n, lp, sdo, rderr, cs_n, rd_n, sclk, sh, soe;
    logic [15:0] res_a = 16'hA5C3, res_b = 16'h3C5A;
    wire [15:0] pdata, poe;
    int num_errors = 0, comparisons = 0, bc, ec, fc, hc;
    logic [31:0] w;
    initial forever #5 clk_sys = !clk_sys;
    dsc_conv_ctrl #(.CONV_CYC(4), .ACQ_CYC(4)) dsc_conv_ctrl_i (
        .clk_sys_i(clk_sys), .sys_rst_i(sys_rst), .convert_start_n_i(cnv_n),
        .power_down_i(pd), .impulse_mode_i(imp), .serial_parallel_select_i(ser),
        .clock_source_select_i(ext), .channel_order_i(ord), .chip_select_n_i(cs_n),
        .read_n_i(rd_n), .serial_clk_i(sclk), .result_a_i(res_a), .result_b_i(res_b),
        .busy_o(busy), .end_of_conv_n_o(eoc_n), .sample_hold_o(sh), .low_power_o(lp),
        .parallel_data_o(pdata), .parallel_data_oe_o(poe), .serial_result_out_o(sdo),
        .serial_result_out_oe_o(soe), .incomplete_read_flag_o(rderr));
    dsc_host dsc_host_i (.chip_select_n_o(cs_n), .read_n_o(rd_n), .serial_clk_o(sclk),
        .serial_result_out_i(sdo));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one start edge, then tally busy, end-of-conversion and error cycles
    task automatic conv;
        {bc, ec, fc, hc} = '0;
        cnv_n = 1'b0;
        for (int i = 0; i < 27; i++) begin
            @(negedge clk_sys);
            if (i == 2) cnv_n = 1'b1;
            bc += (busy === 1'b1);
            ec += (eoc_n === 1'b0);
            fc += (rderr === 1'b1);
            hc += (sh === 1'b1);
        end
    endtask
    task automatic t_par;
        conv();
        chk("busy cycles", 8, bc);
        chk("eoc low cycles", 4, ec);
        chk("hold cycles", 8, hc);
        chk("busy before read", 0, busy);
        dsc_host_i.select(1'b1);
        @(negedge clk_sys);
        chk("parallel word", 16'h3C5A, pdata);
        chk("parallel enables", 16'hFFFF, poe);
        chk("serial enable", 0, soe);
        dsc_host_i.select(1'b0);
        @(negedge clk_sys);
        chk("idle enables", 16'h0000, poe);
        $display("parallel test done");
    endtask
    task automatic t_ser;
        ser = 1'b1;
        ord = 1'b1;
        conv();
        dsc_host_i.read_serial(32, w);
        @(negedge clk_sys);
        chk("serial frame", 32'hA5C33C5A, w);
        conv();
        dsc_host_i.read_serial(5, w);
        @(negedge clk_sys);
        conv();
        chk("error flag cycles", 2, fc);
        $display("serial test done");
    endtask
    task automatic t_pd_rst;
        pd = 1'b1;
        repeat (6) @(negedge clk_sys);
        chk("low power", 1, lp);
        conv();
        chk("busy while down", 0, bc);
        pd = 1'b0;
        cnv_n = 1'b0;
        repeat (6) @(negedge clk_sys);
        cnv_n = 1'b1;
        chk("busy before reset", 1, busy);
        sys_rst = 1'b1;
        @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (12) @(negedge clk_sys);
        chk("busy after reset", 0, busy);
        $display("power down and reset test done");
    endtask
    task automatic t_imp;
        imp = 1'b1;
        cnv_n = 1'b0;
        bc = 0;
        repeat (60) @(negedge clk_sys) bc += (busy === 1'b1);
        chk("impulse busy cycles", 40, bc);
        cnv_n = 1'b1;
        imp = 1'b0;
        $display("impulse test done");
    endtask
    initial begin
        repeat (10) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        t_par();
        t_ser();
        t_pd_rst();
        t_imp();
        complete_run();
    end
    initial begin
        #30000;
        num_errors++;
        complete_run();
    end
endmodule

//--- rtl/dsc_conv_ctrl.v
// conversion control, result latch and output ports of the dual converter
// Summary of operation
// - In serial mode with external clock, bit-11 output is an error flag pulsed high when a read is unfinished at the next conversion end, and that data is dropped.
// - Parallel mode drives bits 0 to 15; serial mode releases the bit 12 to 15 outputs.
// - Busy rises when a conversion starts and falls once both results sit in the shift register.
// - End-of-conversion goes low once per channel conversion finished.
// - Output buses are enabled only while chip select and read strobe are both low.
// - Chip select gates the external serial clock so its edges count only while selected.
// - A high reset level resets the block and aborts any conversion.
// - Power-down lets a running conversion finish and then refuses new starts.
// - A falling edge on convert start holds the samples and begins a conversion.
// - In impulse mode a convert start already low when acquisition ends starts a conversion at once.
// - Both results live in a 32-bit shift register sent MSB first in the selected channel order.
`include "dsc_defines.vh"
module dsc_conv_ctrl #(
    parameter CONV_CYC = `DSC_CONV_CYC,
    parameter ACQ_CYC = `DSC_ACQ_CYC
) (
    input wire clk_sys_i,
    input wire sys_rst_i,
    input wire convert_start_n_i,
    input wire power_down_i,
    input wire impulse_mode_i,
    input wire serial_parallel_select_i,
    input wire clock_source_select_i,
    input wire channel_order_i,
    input wire chip_select_n_i,
    input wire read_n_i,
    input wire serial_clk_i,
    input wire [15:0] result_a_i,
    input wire [15:0] result_b_i,
    output reg busy_o,
    output reg end_of_conv_n_o,
    output reg sample_hold_o,
    output reg low_power_o,
    output reg [15:0] parallel_data_o,
    output wire [15:0] parallel_data_oe_o,
    output reg serial_result_out_o,
    output wire serial_result_out_oe_o,
    output wire incomplete_read_flag_o
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_CONV_A = 4'b0010;
    localparam ST_CONV_B = 4'b0100;
    localparam ST_ACQ = 4'b1000;
    localparam [15:0] CONV_LOAD = CONV_CYC - 1;
    localparam [15:0] ACQ_LOAD = ACQ_CYC - 1;
    localparam [1:0] EOC_HOLD = `DSC_EOC_CYC - 1;
    localparam [1:0] ERR_HOLD = `DSC_ERR_CYC;
    localparam [5:0] FRAME_BITS = `DSC_SHIFT_BITS;

    // saturating step so a counter never wraps if a state is entered oddly
    function [15:0] step_down;
        input [15:0] value;
        begin
            if (value == 16'h0000)
                step_down = 16'h0000;
            else
                step_down = value - 16'h0001;
        end
    endfunction

    function [1:0] tick_down;
        input [1:0] value;
        begin
            if (value == 2'h0)
                tick_down = 2'h0;
            else
                tick_down = value - 2'h1;
        end
    endfunction

    // first channel word sits in the top half so it leaves first
    function [31:0] pack_results;
        input a_first;
        input [15:0] word_a;
        input [15:0] word_b;
        begin
            if (a_first)
                pack_results = {word_a, word_b};
            else
                pack_results = {word_b, word_a};
        end
    endfunction

    // two-flop synchronisers for the nine control pins from outside the clock domain; the result buses are sampled directly
    reg [8:0] sync1;
    reg [8:0] sync2;
    reg cnv_d;
    reg sck_d;
    wire cnv_s = sync2[0];
    wire pd_s = sync2[1];
    wire imp_s = sync2[2];
    wire ser_s = sync2[3];
    wire ext_s = sync2[4];
    wire cs_n_s = sync2[5];
    wire sck_s = sync2[6];
    wire rd_n_s = sync2[7];
    wire ord_s = sync2[8];

    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            // idle pin levels, so no false edge or power-down follows reset
            sync1 <= `DSC_PIN_IDLE;
            sync2 <= `DSC_PIN_IDLE;
            cnv_d <= 1'b1;
            sck_d <= 1'b0;
        end else begin
            sync1 <= {channel_order_i, read_n_i, serial_clk_i, chip_select_n_i,
                clock_source_select_i, serial_parallel_select_i, impulse_mode_i,
                power_down_i, convert_start_n_i};
            sync2 <= sync1;
            cnv_d <= cnv_s;
            sck_d <= sck_s;
        end
    end

    reg [3:0] state;
    reg [3:0] next_state;
    reg [15:0] cnt;
    reg [15:0] next_cnt;
    reg [31:0] shreg;
    reg [5:0] bits_left;
    reg [1:0] eoc_cnt;
    reg [1:0] err_cnt;
    reg err_pulse;
    reg rd_armed;

    wire cnv_fall = cnv_d & ~cnv_s;
    // enables follow the pins: a synchronised copy would keep
    // the bus driven for two cycles after the host lets go
    wire bus_en = ~chip_select_n_i & ~read_n_i;
    wire bus_en_s = ~cs_n_s & ~rd_n_s;
    wire sck_rise = sck_s & ~sck_d & ~cs_n_s;
    wire slave_ser = ser_s & ext_s;
    wire in_idle = state == ST_IDLE;
    wire in_acq = state == ST_ACQ;
    wire cnt_zero = cnt == 16'h0000;
    wire acq_done = in_acq & cnt_zero;
    // impulse acquisition ends with start already low: no edge needed
    wire acq_start = acq_done & ~cnv_s;
    wire edge_start = cnv_fall & (in_idle | acq_done);
    wire start = (edge_start | acq_start) & ~pd_s;
    wire chan_a_done = (state == ST_CONV_A) & cnt_zero;
    wire chan_b_done = (state == ST_CONV_B) & cnt_zero;
    wire chan_done = chan_a_done | chan_b_done;
    wire reading = bits_left != 6'h00;
    // one 32-bit read per fresh result, started once the strobes settle
    wire read_go = in_idle & bus_en_s & ser_s & ~reading & ~busy_o
        & ~sck_rise & rd_armed;

    always @* begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_CONV_A;
                    next_cnt = CONV_LOAD;
                end
            end
            ST_CONV_A: begin
                if (cnt_zero) begin
                    next_state = ST_CONV_B;
                    next_cnt = CONV_LOAD;
                end else begin
                    next_cnt = step_down(cnt);
                end
            end
            ST_CONV_B: begin
                if (cnt_zero) begin
                    if (imp_s) begin
                        next_state = ST_ACQ;
                        next_cnt = ACQ_LOAD;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end else begin
                    next_cnt = step_down(cnt);
                end
            end
            ST_ACQ: begin
                if (!cnt_zero) begin
                    next_cnt = step_down(cnt);
                end else if (start) begin
                    next_state = ST_CONV_A;
                    next_cnt = CONV_LOAD;
                end else if (cnv_s) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_cnt = 16'h0000;
            end
        endcase
    end

    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state <= ST_IDLE;
            cnt <= 16'h0000;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            busy_o <= 1'b0;
            sample_hold_o <= 1'b0;
        end else if (start) begin
            busy_o <= 1'b1;
            sample_hold_o <= 1'b1;
        end else if (chan_b_done) begin
            busy_o <= 1'b0;
            sample_hold_o <= 1'b0;
        end
    end

    always @(posedge clk_sys_i) begin
        if (sys_rst_i)
            low_power_o <= 1'b0;
        else
            low_power_o <= pd_s & in_idle;
    end

    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            eoc_cnt <= 2'h0;
            err_cnt <= 2'h0;
            err_pulse <= 1'b0;
        end else begin
            eoc_cnt <= tick_down(eoc_cnt);
            err_cnt <= tick_down(err_cnt);
            err_pulse <= err_cnt != 2'h0;
            if (chan_done)
                eoc_cnt <= EOC_HOLD;
            // unfinished slave read: old data is lost, flag it
            if (chan_b_done && reading && slave_ser)
                err_cnt <= ERR_HOLD;
        end
    end

    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            shreg <= 32'h0000_0000;
            bits_left <= 6'h00;
        end else if (chan_b_done) begin
            // a fresh result replaces whatever was still being shifted
            shreg <= pack_results(ord_s, result_a_i, result_b_i);
            bits_left <= 6'h00;
        end else if (read_go) begin
            bits_left <= FRAME_BITS;
        end else if (sck_rise && reading) begin
            shreg <= {shreg[30:0], 1'b0};
            bits_left <= bits_left - 6'h01;
        end
    end

    always @(posedge clk_sys_i) begin
        if (sys_rst_i)
            rd_armed <= 1'b0;
        else if (chan_b_done)
            rd_armed <= 1'b1;
        else if (read_go)
            rd_armed <= 1'b0;
    end

    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            end_of_conv_n_o <= 1'b1;
            parallel_data_o <= 16'h0000;
            serial_result_out_o <= 1'b0;
        end else begin
            // low on the edge a channel finishes, so the second pulse
            // begins together with the fall of busy
            end_of_conv_n_o <= ~chan_done & (eoc_cnt == 2'h0);
            serial_result_out_o <= shreg[31];
            parallel_data_o <= ser_s ? 16'h0000 : shreg[31:16];
            if (slave_ser)
                parallel_data_o[`DSC_ERR_BIT] <= err_pulse;
        end
    end

    wire drive_par = bus_en & ~ser_s;
    // the bit 11 flag shares the pin with the bus, so it needs the strobes too
    assign parallel_data_oe_o = {{4{drive_par}},
        bus_en & (~ser_s | slave_ser), {11{drive_par}}};
    assign serial_result_out_oe_o = bus_en & ser_s;
    assign incomplete_read_flag_o = slave_ser & err_pulse;
endmodule

//--- rtl/dsc_defines.vh
// constants for the dual converter conversion control block
`ifndef DSC_DEFINES_VH
`define DSC_DEFINES_VH
`define DSC_RES_BITS 16
`define DSC_SHIFT_BITS 32
`define DSC_CLK_NS 10
`define DSC_CONV_NS 760
`define DSC_CONV_CYC ((`DSC_CONV_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_ACQ_NS 250
`define DSC_ACQ_CYC ((`DSC_ACQ_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_EOC_CYC 2
`define DSC_ERR_CYC 2
`define DSC_ERR_BIT 11
`define DSC_HI_LSB 12
`define DSC_PIN_IDLE 9'h0A1
`endif
